// >>> hdl/arc_pkg.sv
// constants and register layout of the result window compare block
package arc_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_UNITS = 2;
  localparam int THR_W     = 12;
  localparam int LIM_W     = 4;
  localparam int CH_W      = 3;
  localparam int CNT_W     = 5;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMP0_OFS      = 8'h28;
  localparam logic [7:0] CMP1_OFS      = 8'h2C;
  localparam logic [7:0] FLAG_OFS      = 8'h30;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h34;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h38;
  localparam logic [7:0] MATCH_CNT_OFS = 8'h3C;

  // ---------------------------------------------------------------
  // compare configuration fields
  // ---------------------------------------------------------------
  localparam int THR_LSB = 16;
  localparam int THR_MSB = 27;
  localparam int LIM_LSB = 8;
  localparam int LIM_MSB = 11;
  localparam int CH_LSB  = 3;
  localparam int CH_MSB  = 5;
  localparam int DIR_BIT = 2;
  localparam int IE_BIT  = 1;
  localparam int EN_BIT  = 0;

  // writable bits of a compare configuration word
  localparam logic [31:0] CFG_WMASK = 32'h0FFF_0F3F;

  // flag register: unit n flag at bit FLAG_LSB + n
  localparam int FLAG_LSB = 1;

  // match count readback: unit n at bits [8n+4:8n]
  localparam int CNT_STRIDE = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0]          CFG_RESET  = 32'h0000_0000;
  localparam logic [NUM_UNITS-1:0] FLAG_RESET = 2'h0;
  localparam logic [NUM_UNITS-1:0] MASK_RESET = 2'h0;

endpackage

// >>> hdl/arc_compare_unit.sv
// one compare unit: threshold test, match counter and flag event
`timescale 1ns/1ps
`default_nettype none

module arc_compare_unit
  import arc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             unitEnable,
  input  wire logic             direction,
  input  wire logic [CH_W-1:0]  channelSel,
  input  wire logic [THR_W-1:0] threshold,
  input  wire logic [LIM_W-1:0] matchLimit,
  input  wire logic             formatSigned,
  input  wire logic             resultLoad,
  input  wire logic [CH_W-1:0]  resultChannel,
  input  wire logic [THR_W-1:0] resultData,
  output logic                  flagSet,
  output logic [CNT_W-1:0]      matchCount
);

  // ---------------------------------------------------------------
  // compare
  // ---------------------------------------------------------------
  logic             lessUns;
  logic             lessSig;
  logic             less;
  logic             hit;
  logic             hitNow;
  logic [CNT_W-1:0] cntInc;
  logic [CNT_W-1:0] cntTarget;
  logic             reach;
  logic [CNT_W-1:0] cnt_q;
  logic             flagSet_q;

  // unsigned or two's-complement ordering
  assign lessUns = resultData < threshold;
  assign lessSig = $signed(resultData) < $signed(threshold);
  assign less    = formatSigned ? lessSig : lessUns;
  // below threshold or at/above it
  assign hit     = direction ? !less : less;
  // only the selected channel, only on a result load, only when enabled
  assign hitNow  = unitEnable && resultLoad && hit
                   && (resultChannel == channelSel);

  // ---------------------------------------------------------------
  // match counter
  // ---------------------------------------------------------------
  assign cntInc    = cnt_q + CNT_W'(1);
  assign cntTarget = {1'b0, matchLimit} + CNT_W'(1);
  assign reach     = cntInc == cntTarget;

  // count matches, restart on disable and after the flag event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (!unitEnable) begin
      cnt_q <= '0;
    end else if (hitNow) begin
      cnt_q <= reach ? '0 : cntInc;
    end
  end

  // one-cycle flag event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flagSet_q <= 1'b0;
    end else begin
      flagSet_q <= hitNow && reach;
    end
  end

  assign flagSet    = flagSet_q;
  assign matchCount = cnt_q;

endmodule

`default_nettype wire

// >>> hdl/arc_window_compare.sv
// result window compare block with its AHB-Lite register slave
//
// Overview of operation
// - two independent units, own config and flag
// - 12-bit threshold held in bits 27:16
// - format select 0: unsigned compare
// - format select 1: two's-complement compare
// - each match increments counter; limit bits 11:8
// - flag set when count reaches limit plus one
// - channel select bits 5:3 picks channel
// - direction 0: match when result below threshold
// - direction 1: match when result at/above threshold
// - flag with irq enable requests interrupt
// - compare only when enabled, on result load
// - flag stays until written with one
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module arc_window_compare
  import arc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // conversion result path
  input  wire logic             resultLoad,
  input  wire logic [CH_W-1:0]  resultChannel,
  input  wire logic [THR_W-1:0] resultData,
  input  wire logic             resultFormatSelect,
  // requests
  output logic [NUM_UNITS-1:0]  compareIrqReq,
  output logic                  irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]          cfg_q [NUM_UNITS];
  logic [NUM_UNITS-1:0] compareFlag_q;
  logic [NUM_UNITS-1:0] irqStat_q;
  logic [NUM_UNITS-1:0] irqMask_q;
  logic [NUM_UNITS-1:0] flagSet;
  logic [CNT_W-1:0]     matchCount [NUM_UNITS];

  // configuration fields of each unit
  logic [NUM_UNITS-1:0] unitEn;
  logic [NUM_UNITS-1:0] unitIrqEn;
  logic [NUM_UNITS-1:0] unitDir;
  logic [CH_W-1:0]      unitCh [NUM_UNITS];
  logic [THR_W-1:0]     unitThr [NUM_UNITS];
  logic [LIM_W-1:0]     unitLim [NUM_UNITS];

  logic                 addrPhase;
  logic                 wrPend_q;
  logic [7:0]           wrAddr_q;
  logic [7:0]           rdAddr;
  logic                 rdAccept;
  logic [31:0]          rdData_d;
  logic [31:0]          hrdata_q;

  logic                 wrStrobe;
  logic                 wrCfg0;
  logic                 wrCfg1;
  logic                 wrFlag;
  logic                 wrMask;
  logic                 rdIrqStat;
  logic [NUM_UNITS-1:0] flagClr;
  logic [NUM_UNITS-1:0] irqStatClr;
  logic [31:0]          flagWord;
  logic [31:0]          cntWord;
  logic [31:0]          statWord;
  logic [31:0]          maskWord;

  // ---------------------------------------------------------------
  // bus address phase
  // ---------------------------------------------------------------
  // a transfer is taken when selected, nonseq/seq and the bus is ready
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdAccept  = addrPhase && !hwrite;
  assign rdAddr    = haddr[7:0];

  // ---------------------------------------------------------------
  // bus response
  // ---------------------------------------------------------------
  // every transfer completes with no wait and an OKAY response
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // write data phase
  // ---------------------------------------------------------------
  // a write data phase follows its address phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q <= 1'b0;
    end else if (hready) begin
      wrPend_q <= addrPhase && hwrite;
    end
  end

  // hold a write address for its data phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrAddr_q <= 8'h00;
    end else if (addrPhase && hwrite) begin
      wrAddr_q <= haddr[7:0];
    end
  end

  // write data is taken when the data phase ends
  assign wrStrobe = wrPend_q && hready;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // one strobe per writable offset
  always_comb begin
    wrCfg0 = 1'b0;
    wrCfg1 = 1'b0;
    wrFlag = 1'b0;
    wrMask = 1'b0;
    if (wrStrobe) begin
      case (wrAddr_q)
        CMP0_OFS: begin
          wrCfg0 = 1'b1;
        end
        CMP1_OFS: begin
          wrCfg1 = 1'b1;
        end
        FLAG_OFS: begin
          wrFlag = 1'b1;
        end
        IRQ_MASK_OFS: begin
          wrMask = 1'b1;
        end
        default: begin
          wrMask = 1'b0;
        end
      endcase
    end
  end

  // a read of the interrupt status word clears it
  assign rdIrqStat = rdAccept && (rdAddr == IRQ_STAT_OFS);

  // ---------------------------------------------------------------
  // compare configuration registers
  // ---------------------------------------------------------------
  // unit 0 configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q[0] <= CFG_RESET;
    end else if (wrCfg0) begin
      cfg_q[0] <= hwdata & CFG_WMASK;
    end
  end

  // unit 1 configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q[1] <= CFG_RESET;
    end else if (wrCfg1) begin
      cfg_q[1] <= hwdata & CFG_WMASK;
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqMask_q <= MASK_RESET;
    end else if (wrMask) begin
      irqMask_q <= hwdata[NUM_UNITS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // compare units
  // ---------------------------------------------------------------
  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : gUnit
      // configuration fields of this unit
      assign unitEn[u]    = cfg_q[u][EN_BIT];
      assign unitIrqEn[u] = cfg_q[u][IE_BIT];
      assign unitDir[u]   = cfg_q[u][DIR_BIT];
      assign unitCh[u]    = cfg_q[u][CH_MSB:CH_LSB];
      assign unitThr[u]   = cfg_q[u][THR_MSB:THR_LSB];
      assign unitLim[u]   = cfg_q[u][LIM_MSB:LIM_LSB];

      // each unit sees only its own configuration word
      arc_compare_unit uUnit (
        .clk           (clk),
        .arst_n        (arst_n),
        .unitEnable    (unitEn[u]),
        .direction     (unitDir[u]),
        .channelSel    (unitCh[u]),
        .threshold     (unitThr[u]),
        .matchLimit    (unitLim[u]),
        .formatSigned  (resultFormatSelect),
        .resultLoad    (resultLoad),
        .resultChannel (resultChannel),
        .resultData    (resultData),
        .flagSet       (flagSet[u]),
        .matchCount    (matchCount[u])
      );

      // write one clears the flag, zero leaves it
      assign flagClr[u] = wrFlag && hwdata[FLAG_LSB+u];

      // a read of the status word clears every unit's bit
      assign irqStatClr[u] = rdIrqStat;

      // per-unit request: flag while its interrupt enable is set
      assign compareIrqReq[u] = compareFlag_q[u] && unitIrqEn[u];
    end
  endgenerate

  // ---------------------------------------------------------------
  // compare flags
  // ---------------------------------------------------------------
  // sticky until cleared; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compareFlag_q <= FLAG_RESET;
    end else begin
      compareFlag_q <= flagSet | (compareFlag_q & ~flagClr);
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  // events that request an interrupt, cleared by reading the word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_q <= FLAG_RESET;
    end else begin
      irqStat_q <= (flagSet & unitIrqEn) | (irqStat_q & ~irqStatClr);
    end
  end

  // ---------------------------------------------------------------
  // interrupt output
  // ---------------------------------------------------------------
  // one level output for all unmasked status bits
  assign irq = |(irqStat_q & irqMask_q);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // flag word with unit n at bit FLAG_LSB + n, unused bits zero
  always_comb begin
    flagWord = 32'h0000_0000;
    flagWord[FLAG_LSB +: NUM_UNITS] = compareFlag_q;
  end

  // live match counters, one byte lane per unit
  always_comb begin
    cntWord = 32'h0000_0000;
    for (int i = 0; i < NUM_UNITS; i++) begin
      cntWord[i*CNT_STRIDE +: CNT_W] = matchCount[i];
    end
  end

  // interrupt status word, unused bits zero
  always_comb begin
    statWord = 32'h0000_0000;
    statWord[NUM_UNITS-1:0] = irqStat_q;
  end

  // interrupt mask word, unused bits zero
  always_comb begin
    maskWord = 32'h0000_0000;
    maskWord[NUM_UNITS-1:0] = irqMask_q;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (rdAddr)
      CMP0_OFS: begin
        rdData_d = cfg_q[0];
      end
      CMP1_OFS: begin
        rdData_d = cfg_q[1];
      end
      FLAG_OFS: begin
        rdData_d = flagWord;
      end
      IRQ_STAT_OFS: begin
        rdData_d = statWord;
      end
      IRQ_MASK_OFS: begin
        rdData_d = maskWord;
      end
      MATCH_CNT_OFS: begin
        rdData_d = cntWord;
      end
      default: begin
        rdData_d = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // read data register
  // ---------------------------------------------------------------
  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rdAccept) begin
      hrdata_q <= rdData_d;
    end
  end

  assign hrdata = hrdata_q;

  // ---------------------------------------------------------------
  // unused bus inputs
  // ---------------------------------------------------------------
  // hsize is accepted as a word in every case
  logic unusedSize;
  assign unusedSize = ^{hsize, haddr[31:8]};

endmodule

`default_nettype wire

// >>> tb/arc_window_compare_assertions.sv
// assertion checker for the result window compare block
`timescale 1ns/1ps
`default_nettype none
module arc_window_compare_assertions
  import arc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic                 resultLoad,
  input wire logic [CH_W-1:0]      resultChannel,
  input wire logic [NUM_UNITS-1:0] compareIrqReq,
  input wire logic                 irq
);
  logic        wrPh_q;
  logic [7:0]  wrAddr_q;
  logic [31:0] cfg0_q;
  logic [31:0] cfg1_q;
  logic [1:0]  mask_q;
  logic        hit0;
  logic        addrWr;
  // ---------------------------------------------------------------
  // shadow of written config and mask
  // ---------------------------------------------------------------
  assign addrWr = hsel && htrans[1] && hwrite;
  assign hit0   = resultLoad && cfg0_q[0] && resultChannel == cfg0_q[5:3];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPh_q   <= 1'b0;
      wrAddr_q <= 8'h00;
      cfg0_q   <= 32'h0;
      cfg1_q   <= 32'h0;
      mask_q   <= 2'h0;
    end else begin
      wrPh_q   <= addrWr;
      wrAddr_q <= haddr[7:0];
      if (wrPh_q && wrAddr_q == 8'h28) cfg0_q <= hwdata;
      if (wrPh_q && wrAddr_q == 8'h2C) cfg1_q <= hwdata;
      if (wrPh_q && wrAddr_q == 8'h38) mask_q <= hwdata[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // write of one to the unit 0 flag, no set in the same edge
  sequence flagClear;
    addrWr && haddr[7:0] == 8'h30 ##1 hwdata[1] && !$past(hit0);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  rdy_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  irq_gate0_a: assert property (!cfg0_q[1] |-> !compareIrqReq[0])
    else $error("unit 0 request without enable");
  irq_gate1_a: assert property (!cfg1_q[1] |-> !compareIrqReq[1])
    else $error("unit 1 request without enable");
  flag_cause_a: assert property ($rose(compareIrqReq[0]) && $past(cfg0_q[1]) |-> $past(hit0, 2))
    else $error("unit 0 flag without selected load");
  flag_hold_a: assert property (compareIrqReq[0] && !(wrPh_q && wrAddr_q == 8'h30)
    |=> compareIrqReq[0] || !cfg0_q[1])
    else $error("unit 0 flag dropped by itself");
  flag_clear_a: assert property (flagClear |=> !compareIrqReq[0])
    else $error("unit 0 flag not cleared");
  rdata_hold_a: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without read");
  irq_masked_a: assert property (mask_q == 2'h0 |-> !irq)
    else $error("interrupt while fully masked");
endmodule
bind arc_window_compare arc_window_compare_assertions chk (.clk(clk), .arst_n(arst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .resultLoad(resultLoad),
  .resultChannel(resultChannel), .compareIrqReq(compareIrqReq), .irq(irq));
`default_nettype wire

// >>> tb/arc_result_source.sv
// model of the converter result path feeding the compare block
`timescale 1ns/1ps
`default_nettype none
module arc_result_source
  import arc_pkg::*;
(
  input  wire logic        clk,
  output logic             resultLoad,
  output logic [CH_W-1:0]  resultChannel,
  output logic [THR_W-1:0] resultData,
  output logic             resultFormatSelect
);
  initial begin
    resultLoad         = 1'b0;
    resultChannel      = '0;
    resultData         = '0;
    resultFormatSelect = 1'b0;
  end
  // one result per call as a single-cycle load pulse
  task automatic send(input logic [CH_W-1:0] ch, input logic [THR_W-1:0] d);
    @(posedge clk);
    resultLoad    <= 1'b1;
    resultChannel <= ch;
    resultData    <= d;
    @(posedge clk);
    resultLoad    <= 1'b0;
    resultChannel <= ~ch; // stale lines never keep their value
    resultData    <= ~d;
  endtask
  // number format of the results
  task automatic setFmt(input logic f);
    @(posedge clk);
    resultFormatSelect <= f;
  endtask
endmodule
`default_nettype wire

// >>> tb/arc_window_compare_tb.sv
// testbench of the result window compare block
`timescale 1ns/1ps
`default_nettype none
module arc_window_compare_tb
  import arc_pkg::*;
;
  logic                 clk, arst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]           htrans;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  logic                 resultLoad, resultFormatSelect;
  logic [CH_W-1:0]      resultChannel;
  logic [THR_W-1:0]     resultData;
  logic [NUM_UNITS-1:0] compareIrqReq;
  int                   miscompares = 0;
  int                   n_checks = 0;
  logic [7:0]  ofs [6]  = '{8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  logic        fmtT [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
  logic        dirT [6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1};
  logic        hitT [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
  logic [11:0] thrT [6] = '{12'h800, 12'h800, 12'h800, 12'h000, 12'h000, 12'h7FF};
  logic [11:0] datT [6] = '{12'h7FF, 12'h800, 12'h800, 12'hFFF, 12'hFFF, 12'h800};
  arc_window_compare dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .resultLoad(resultLoad),
    .resultChannel(resultChannel), .resultData(resultData),
    .resultFormatSelect(resultFormatSelect), .compareIrqReq(compareIrqReq), .irq(irq));
  arc_result_source src (.clk(clk), .resultLoad(resultLoad), .resultChannel(resultChannel),
    .resultData(resultData), .resultFormatSelect(resultFormatSelect));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic waitRdy();
    int i = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      if (++i > 16) begin
        miscompares++;
        $display("wrong value at %0t: bus ready timeout", $time);
        wrap_up();
      end
      @(posedge clk);
    end
  endtask
  // one single AHB-Lite word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] cfg(logic [11:0] thr, logic [3:0] lim, logic [2:0] ch,
                                      logic dir, logic ie, logic en);
    return {4'h0, thr, 4'h0, lim, 2'h0, ch, dir, ie, en};
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    hsel   = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ofs[i]) rdchk(ofs[i], 32'h0);
    bus(1'b1, 8'h28, 32'hFFFF_FFFF);
    bus(1'b1, 8'h2C, 32'h0123_4567);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdchk(8'h28, 32'h0FFF_0F3F);
    rdchk(8'h2C, 32'h0123_0527);
    rdchk(8'h40, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      src.setFmt(fmtT[k]);
      bus(1'b1, 8'h28, cfg(thrT[k], 4'h0, 3'h2, dirT[k], 1'b0, 1'b1));
      src.send(3'h2, datT[k]);
      rdchk(8'h30, {29'h0, 1'b0, hitT[k], 1'b0});
      bus(1'b1, 8'h30, 32'h6);
    end
    $display("test conditions done");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h2C, cfg(12'h000, 4'h0, c[2:0], 1'b1, 1'b1, 1'b1));
      src.send(c[2:0] + 3'h1, 12'h123);
      rdchk(8'h30, 32'h0);
      src.send(c[2:0], 12'h123);
      rdchk(8'h30, 32'h4);
      chk({30'h0, compareIrqReq}, 32'h2);
      bus(1'b1, 8'h30, 32'h4);
    end
    $display("test channels done");
    src.setFmt(1'b0);
    bus(1'b1, 8'h28, cfg(12'h000, 4'h2, 3'h3, 1'b1, 1'b1, 1'b1));
    repeat (2) src.send(3'h3, 12'h000);
    rdchk(8'h3C, 32'h2);
    bus(1'b1, 8'h28, cfg(12'h000, 4'h2, 3'h3, 1'b1, 1'b1, 1'b0));
    src.send(3'h3, 12'h000);
    rdchk(8'h3C, 32'h0);
    bus(1'b1, 8'h28, cfg(12'h000, 4'h2, 3'h3, 1'b1, 1'b1, 1'b1));
    repeat (2) src.send(3'h3, 12'h000);
    rdchk(8'h30, 32'h0);
    src.send(3'h3, 12'h000);
    rdchk(8'h30, 32'h2);
    rdchk(8'h3C, 32'h0);
    chk({30'h0, compareIrqReq}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h38, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rdchk(8'h34, 32'h3);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h30, 32'h0);
    rdchk(8'h30, 32'h2);
    bus(1'b1, 8'h30, 32'h2);
    rdchk(8'h30, 32'h0);
    chk({30'h0, compareIrqReq}, 32'h0);
    $display("test counting and interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
